// ===== dv/encfe_enumerate_sva.sv
// Purpose: port checker for the enclave feature enumeration block
// Assumes: one clock domain, reset active low
// Notes:   bound into every instance, feature parameter handed on
`timescale 1ns/1ns
`default_nettype none
module encfe_enumerate_sva #(
  parameter logic P_FEATURE = 1'b1
) (
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  input wire logic        i_query_valid,
  input wire logic [31:0] i_query_leaf,
  input wire logic [31:0] i_query_subleaf,
  input wire logic        o_query_done,
  input wire logic [31:0] o_result_word_first,
  input wire logic [31:0] o_result_word_second,
  input wire logic [31:0] o_result_word_third,
  input wire logic [31:0] o_result_word_fourth,
  input wire logic [31:0] o_feature_control_register,
  input wire logic        i_encl_valid,
  input wire logic        o_encl_done,
  input wire logic        o_invalid_opcode_fault,
  input wire logic        o_general_protection_fault,
  input wire logic        o_encl_execute,
  input wire logic        o_opted_in
);
  // selectors of the query being answered, one cycle old
  logic [31:0] leaf_q;
  logic [31:0] sub_q;
  always_ff @(posedge i_core_clk) begin
    leaf_q <= i_query_leaf;
    sub_q  <= i_query_subleaf;
  end
  // all four words as one value
  wire logic [127:0] res = {o_result_word_fourth, o_result_word_third,
                            o_result_word_second, o_result_word_first};
  wire logic [31:0]  fc = o_feature_control_register;
  wire logic         on_enc = o_query_done
                              && leaf_q == encfe_pkg::LEAF_ENCLAVE;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  query_done_a:
    assert property (i_query_valid |=> o_query_done)
    else $error("query not answered");
  feature_flag_a:
    assert property (o_query_done && leaf_q == encfe_pkg::LEAF_FEATURES
      && sub_q == 32'h0 |-> res == {93'h0, P_FEATURE, 34'h0})
    else $error("feature flag word wrong");
  sub0_zero_a:
    assert property (on_enc && sub_q == 32'h0 |-> res[4:2] == 3'h0
      && res[31:7] == 25'h0 && res[95:64] == 32'h0 && res[127:112] == 16'h0)
    else $error("reserved capability bits set");
  bad_sub_zero_a:
    assert property (on_enc && sub_q > 32'h3 |-> res == 128'h0)
    else $error("invalid sub-leaf not zero");
  no_feature_a:
    assert property (on_enc && !P_FEATURE |-> res == 128'h0)
    else $error("resource leaf without feature not zero");
  encl_done_a:
    assert property (i_encl_valid |=> o_encl_done && $onehot({
      o_invalid_opcode_fault, o_general_protection_fault, o_encl_execute}))
    else $error("instruction outcome missing");
  ud_flag_a:
    assert property (o_encl_done |-> o_invalid_opcode_fault == !P_FEATURE)
    else $error("invalid opcode fault wrong");
  exec_opt_a:
    assert property (o_encl_execute |-> $past(fc[0] && fc[18]))
    else $error("executed while not opted in");
  opted_in_a:
    assert property (o_opted_in == $past(fc[0] && fc[18]))
    else $error("opted in flag wrong");
  lock_hold_a:
    assert property (fc[0] |=> $stable(fc))
    else $error("locked register changed");

  cover property (o_encl_execute);
  cover property (o_general_protection_fault);
  cover property (on_enc);
endmodule

bind encfe_enumerate encfe_enumerate_sva #(.P_FEATURE(P_FEATURE)) u_sva (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_query_valid(i_query_valid), .i_query_leaf(i_query_leaf),
  .i_query_subleaf(i_query_subleaf), .o_query_done(o_query_done),
  .o_result_word_first(o_result_word_first),
  .o_result_word_second(o_result_word_second),
  .o_result_word_third(o_result_word_third),
  .o_result_word_fourth(o_result_word_fourth),
  .o_feature_control_register(o_feature_control_register),
  .i_encl_valid(i_encl_valid), .o_encl_done(o_encl_done),
  .o_invalid_opcode_fault(o_invalid_opcode_fault),
  .o_general_protection_fault(o_general_protection_fault),
  .o_encl_execute(o_encl_execute), .o_opted_in(o_opted_in));
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench for the enclave feature enumeration block
// Assumes: default parameters, a second copy without the feature
// Notes:   expected words worked out from the parameter defaults
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [127:0] attr_allow = 128'h1F_0000_0000_0000_0036;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic q_v = 1'b0, fc_we = 1'b0, e_v = 1'b0, e_cr = 1'b0;
  logic [31:0] lf = 32'h0, sb = 32'h0, fc_d = 32'h0, m_fc = 32'h0;
  logic [127:0] e_at = 128'h0;
  int error_cnt = 0, samples_checked = 0, n_sect = 0;
  wire logic [31:0] w1 [2], w2 [2], w3 [2], w4 [2], fc_q [2];
  wire logic qd [2], op [2];
  wire logic [3:0] eo [2];

  // core clock
  initial begin
    forever #20 clk = ~clk;
  end

  // copy 0 has the feature, copy 1 has not
  for (genvar g = 0; g < 2; g++) begin : g_dut
    encfe_enumerate #(.P_FEATURE(1'(g == 0))) dut (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_query_valid(q_v),
      .i_query_leaf(lf), .i_query_subleaf(sb), .o_query_done(qd[g]),
      .o_result_word_first(w1[g]), .o_result_word_second(w2[g]),
      .o_result_word_third(w3[g]), .o_result_word_fourth(w4[g]),
      .i_fc_write(fc_we), .i_fc_wdata(fc_d),
      .o_feature_control_register(fc_q[g]), .i_encl_valid(e_v),
      .i_encl_is_create(e_cr), .i_encl_enclave_attribute_field(e_at),
      .o_encl_done(eo[g][3]), .o_invalid_opcode_fault(eo[g][2]),
      .o_general_protection_fault(eo[g][1]), .o_encl_execute(eo[g][0]),
      .o_opted_in(op[g]));
  end

  task automatic chk(input logic [128:0] got, input logic [128:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // reference answer as {fourth, third, second, first}
  function automatic logic [127:0] exp_q(input logic f, input logic [31:0] l,
                                         input logic [31:0] s);
    exp_q = 128'h0;
    if (l == 32'h7 && s == 32'h0) exp_q[34] = f;
    else if (f && l == 32'h12) case (s)
      32'h0: exp_q = {32'h241F, 32'h0, 32'h1, 32'h3};
      32'h1: exp_q = attr_allow;
      32'h2: exp_q = {32'h0, 32'h0400_0001, 32'h0, 32'h4000_0001};
      32'h3: exp_q = {32'h0, 32'h0200_0002, 32'h0, 32'h8000_0001};
      default: ;
    endcase
  endfunction

  task automatic query(input logic [31:0] l, input logic [31:0] s);
    @(posedge clk);
    q_v <= 1'b1;
    lf <= l;
    sb <= s;
    @(posedge clk);
    q_v <= 1'b0;
    #1;
    for (int g = 0; g < 2; g++)
      chk({qd[g], w4[g], w3[g], w2[g], w1[g]},
          {1'b1, exp_q(g == 0, l, s)});
  endtask

  task automatic fcw(input logic [31:0] d);
    @(posedge clk);
    fc_we <= 1'b1;
    fc_d <= d;
    @(posedge clk);
    fc_we <= 1'b0;
    if (!m_fc[0]) m_fc = d;
    @(posedge clk);
    #1;
    chk({96'h0, fc_q[0], op[0]}, {96'h0, m_fc, m_fc[0] & m_fc[18]});
  endtask

  task automatic encl(input logic cr, input logic [127:0] at);
    logic gp;
    @(posedge clk);
    e_v <= 1'b1;
    e_cr <= cr;
    e_at <= at;
    @(posedge clk);
    e_v <= 1'b0;
    #1;
    gp = !(m_fc[0] && m_fc[18]) || (cr && (at & ~attr_allow) != 128'h0);
    chk({125'h0, eo[0]}, {125'h0, 2'b10, gp, !gp});
    chk({125'h0, eo[1]}, {125'h0, 4'b1100});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(39));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int s = 0; s < 6; s++) query(32'h12, 32'(s));
    query(32'h7, 32'h0);
    for (int i = 0; i < 8; i++)
      query(i[0] ? 32'h12 : $urandom, $urandom_range(300, 4));
    // software style scan: walk sections until the type reads invalid
    for (int s = 2; s < 10; s++) begin
      query(32'h12, 32'(s));
      if (w1[0][3:0] != encfe_pkg::SECT_VALID) break;
      n_sect++;
    end
    chk(129'(n_sect), 129'(encfe_pkg::NUM_SECT));
    $display("test query done");
    encl(1'b0, 128'h0);
    fcw(32'h0004_0000);
    encl(1'b0, 128'h0);
    query(32'h12, 32'h0);
    fcw(32'h0004_0001);
    query(32'h12, 32'h1);
    encl(1'b1, attr_allow & {4{$urandom}});
    encl(1'b1, 128'h1);
    fcw(32'h0);
    encl(1'b0, 128'h0);
    $display("test opt-in done");
    @(posedge clk);
    rst_n <= 1'b0;
    m_fc = 32'h0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    fcw(32'h0000_0001);
    fcw(32'h0004_0001);
    encl(1'b0, 128'h0);
    $display("test lock order done");
    end_sim();
  end

  // watchdog
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire

// ===== hdl/encfe_enumerate.sv
// Purpose: answers identification queries for the enclave extension and
//          gates enclave instructions on the firmware opt-in state
// Assumes: one hardware thread per instance; query results registered
// Notes:   feature control register write port lives here as well
//
// Summary of operation
// R1: leaf 07H second word bit 2 flags support
// R2: leaf 12H answered when feature flag set
// R3: sub-leaf content depends on configuration only
// R4: firmware sets opt-in bit before configuration
// R5: opted in only when enable and lock
// R6: opt-in bit writes obey lock rules
// R7: opt-in bit never alters query results
// R8: fault invalid-opcode, general-protection, or execute
// R9: results kept per hardware thread
// R10: configured device returns four valid sub-leaves
// R11: sub-leaf 0 bits 0,1 instruction sets
// R12: bits 5,6 extra sets; others zero
// R13: second word misc mask; third zero
// R14: fourth word max size logs, top zero
// R15: sub-leaf 1 gives attribute masks; creation checks
// R16: sub-leaf 2 up reports memory sections
// R17: software scans sections until invalid type
// R18: invalid sub-leaves return all zero
// R19: type 0000b invalid, 0001b valid section
// R20: base address split across two words
// R21: third word encodes protection type
// R22: no feature means leaf 12H zero
// R23: results depend only on selectors
`timescale 1ns/1ns
`default_nettype none
module encfe_enumerate #(
  parameter logic        P_FEATURE    = 1'b1,
  parameter logic        P_BASE_SET   = 1'b1,
  parameter logic        P_DYN_SET    = 1'b1,
  parameter logic        P_VIRT_SET   = 1'b0,
  parameter logic        P_CONFL_SET  = 1'b0,
  parameter logic [31:0] P_MISC_MASK  = 32'h0000_0001,
  parameter logic [7:0]  P_MAX_LEGACY = 8'h1F,
  parameter logic [7:0]  P_MAX_WIDE   = 8'h24,
  parameter logic [127:0] P_ATTR_MASK  =
    128'h0000_0000_0000_001F_0000_0000_0000_0036,
  parameter logic [103:0] P_SECT_BASE  =
    {52'h0_0000_8000_0000, 52'h0_0000_4000_0000},
  parameter logic [103:0] P_SECT_SIZE  =
    {52'h0_0000_0200_0000, 52'h0_0000_0400_0000},
  parameter logic [7:0]   P_SECT_PROT  = {4'h2, 4'h1}
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // identification query
  input  wire logic        i_query_valid,
  input  wire logic [31:0] i_query_leaf,
  input  wire logic [31:0] i_query_subleaf,
  output logic             o_query_done,
  output logic [31:0]      o_result_word_first,
  output logic [31:0]      o_result_word_second,
  output logic [31:0]      o_result_word_third,
  output logic [31:0]      o_result_word_fourth,
  // feature control register write and read
  input  wire logic        i_fc_write,
  input  wire logic [31:0] i_fc_wdata,
  output logic [31:0]      o_feature_control_register,
  // enclave instruction gate
  input  wire logic        i_encl_valid,
  input  wire logic        i_encl_is_create,
  input  wire logic [127:0] i_encl_enclave_attribute_field,
  output logic             o_encl_done,
  output logic             o_invalid_opcode_fault,
  output logic             o_general_protection_fault,
  output logic             o_encl_execute,
  output logic             o_opted_in
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // two stage release of the asynchronous reset
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // feature control register
  // ---------------------------------------------------------------
  logic [31:0] fc_reg;
  logic [31:0] fc_next;
  logic        fc_locked;
  logic        fc_opt_in;
  logic        opted_in;

  assign fc_locked = fc_reg[encfe_pkg::FC_LOCK_BIT];
  assign fc_opt_in = fc_reg[encfe_pkg::FC_OPT_IN_BIT];
  // R6: lock freezes writes
  assign fc_next   = (i_fc_write && !fc_locked) ? i_fc_wdata : fc_reg;
  // R5: both bits needed
  assign opted_in  = fc_locked && fc_opt_in;

  // register write path, frozen once locked
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fc_reg <= 32'h0000_0000;
    end else begin
      fc_reg <= fc_next;
    end
  end

  // ---------------------------------------------------------------
  // query decode
  // ---------------------------------------------------------------
  // one select bit covers the two built-in sections
  localparam int NUM_IDX_W = 1;

  logic        is_feat_leaf;
  logic        is_encl_leaf;
  logic        sub_is_caps;
  logic        sub_is_attrs;
  logic        sub_is_sect;
  logic [31:0] sect_idx;
  logic        sect_in_range;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [31:0] w4;
  logic [31:0] caps_first;
  logic [31:0] caps_fourth;
  logic [51:0] sect_base;
  logic [51:0] sect_size;
  logic [3:0]  sect_prot;
  logic [31:0] sect_w1;
  logic [31:0] sect_w2;
  logic [31:0] sect_w3;
  logic [31:0] sect_w4;
  logic [NUM_IDX_W-1:0] sect_sel;

  assign is_feat_leaf = (i_query_leaf == encfe_pkg::LEAF_FEATURES)
                        && (i_query_subleaf == encfe_pkg::SUB_CAPS);
  // R2: leaf 12H only with feature
  // R22: absent feature gives zeros
  assign is_encl_leaf = (i_query_leaf == encfe_pkg::LEAF_ENCLAVE)
                        && P_FEATURE;
  assign sub_is_caps  = (i_query_subleaf == encfe_pkg::SUB_CAPS);
  assign sub_is_attrs = (i_query_subleaf == encfe_pkg::SUB_ATTRS);
  assign sect_idx     = i_query_subleaf - encfe_pkg::SUB_SECT_FIRST;
  // R16: sections need both instruction sets
  assign sect_in_range = (i_query_subleaf >= encfe_pkg::SUB_SECT_FIRST)
                         && (sect_idx < 32'(encfe_pkg::NUM_SECT))
                         && P_BASE_SET && P_DYN_SET;
  assign sect_sel     = sect_idx[NUM_IDX_W-1:0];

  // R11: instruction set bits
  // R12: extra sets, reserved bits zero
  always_comb begin
    caps_first = 32'h0000_0000;
    caps_first[encfe_pkg::CAP_BASE_BIT]  = P_BASE_SET;
    caps_first[encfe_pkg::CAP_DYN_BIT]   = P_DYN_SET;
    caps_first[encfe_pkg::CAP_VIRT_BIT]  = P_VIRT_SET;
    caps_first[encfe_pkg::CAP_CONFL_BIT] = P_CONFL_SET;
  end
  // R14: size logs, upper half zero
  assign caps_fourth = {16'h0000, P_MAX_WIDE, P_MAX_LEGACY};

  // section table lookup
  assign sect_base = P_SECT_BASE[sect_sel*52 +: 52];
  assign sect_size = P_SECT_SIZE[sect_sel*52 +: 52];
  assign sect_prot = P_SECT_PROT[sect_sel*4 +: 4];
  // R19: valid type code
  // R20: base address split
  assign sect_w1 = {sect_base[31:12], 8'h00, encfe_pkg::SECT_VALID};
  assign sect_w2 = {12'h000, sect_base[51:32]};
  // R21: protection encoding
  assign sect_w3 = {sect_size[31:12], 8'h00, sect_prot};
  assign sect_w4 = {12'h000, sect_size[51:32]};

  // R7: opt-in bit never read here
  // R23: selection from selectors only
  // R10: caps, enclave_attribute_field, sections valid
  always_comb begin
    w1 = 32'h0000_0000;
    w2 = 32'h0000_0000;
    w3 = 32'h0000_0000;
    w4 = 32'h0000_0000;
    if (is_feat_leaf) begin
      // R1: feature flag bit
      w2[encfe_pkg::FEAT_ENCLAVE_BIT] = P_FEATURE;
    end else if (is_encl_leaf && sub_is_caps) begin
      // R13: misc mask, third word zero
      w1 = caps_first;
      w2 = P_MISC_MASK;
      w4 = caps_fourth;
    end else if (is_encl_leaf && sub_is_attrs) begin
      // R15: attribute masks
      w1 = P_ATTR_MASK[31:0];
      w2 = P_ATTR_MASK[63:32];
      w3 = P_ATTR_MASK[95:64];
      w4 = P_ATTR_MASK[127:96];
    end else if (is_encl_leaf && sect_in_range) begin
      // R3: configured sections only
      w1 = sect_w1;
      w2 = sect_w2;
      w3 = sect_w3;
      w4 = sect_w4;
    end
    // R18: anything else stays zero
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  // R9: one copy per thread instance
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_query_done         <= 1'b0;
      o_result_word_first  <= 32'h0000_0000;
      o_result_word_second <= 32'h0000_0000;
      o_result_word_third  <= 32'h0000_0000;
      o_result_word_fourth <= 32'h0000_0000;
    end else begin
      o_query_done <= i_query_valid;
      if (i_query_valid) begin
        o_result_word_first  <= w1;
        o_result_word_second <= w2;
        o_result_word_third  <= w3;
        o_result_word_fourth <= w4;
      end
    end
  end

  // ---------------------------------------------------------------
  // enclave instruction gate
  // ---------------------------------------------------------------
  encfe_pkg::encfe_outcome_t outcome;
  logic attr_ok;

  // R15: creation refuses unmasked enclave_attribute_field
  assign attr_ok = !i_encl_is_create
                   || ((i_encl_enclave_attribute_field & ~P_ATTR_MASK) == 128'h0);

  // R8: fault selection
  assign outcome = !P_FEATURE ? encfe_pkg::ENCFE_EXEC_UD :
                   !opted_in  ? encfe_pkg::ENCFE_EXEC_GP :
                   !attr_ok   ? encfe_pkg::ENCFE_EXEC_GP :
                                encfe_pkg::ENCFE_EXEC_OK;

  // registered outcome of each enclave instruction
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_encl_done                <= 1'b0;
      o_invalid_opcode_fault     <= 1'b0;
      o_general_protection_fault <= 1'b0;
      o_encl_execute             <= 1'b0;
      o_opted_in                 <= 1'b0;
      o_feature_control_register <= 32'h0000_0000;
    end else begin
      o_encl_done                <= i_encl_valid;
      o_invalid_opcode_fault     <= i_encl_valid &&
                                    (outcome == encfe_pkg::ENCFE_EXEC_UD);
      o_general_protection_fault <= i_encl_valid &&
                                    (outcome == encfe_pkg::ENCFE_EXEC_GP);
      o_encl_execute             <= i_encl_valid &&
                                    (outcome == encfe_pkg::ENCFE_EXEC_OK);
      o_opted_in                 <= opted_in;
      o_feature_control_register <= fc_next;
    end
  end

endmodule
`default_nettype wire

// ===== pkg/encfe_pkg.sv
// Purpose: constants for the enclave feature enumeration block
// Assumes: 32-bit result words, leaf and sub-leaf selectors 32 bits
// Notes:   capability values are parameters of the top module
package encfe_pkg;
  // leaves
  localparam logic [31:0] LEAF_FEATURES  = 32'h0000_0007;
  localparam logic [31:0] LEAF_ENCLAVE   = 32'h0000_0012;
  localparam logic [31:0] SUB_CAPS       = 32'h0000_0000;
  localparam logic [31:0] SUB_ATTRS      = 32'h0000_0001;
  localparam logic [31:0] SUB_SECT_FIRST = 32'h0000_0002;
  // feature control register bits
  localparam int FC_LOCK_BIT   = 0;
  localparam int FC_OPT_IN_BIT = 18;
  // leaf 07H second word
  localparam int FEAT_ENCLAVE_BIT = 2;
  // sub-leaf 0 first word bits
  localparam int CAP_BASE_BIT    = 0;
  localparam int CAP_DYN_BIT     = 1;
  localparam int CAP_VIRT_BIT    = 5;
  localparam int CAP_CONFL_BIT   = 6;
  // field widths
  localparam int MAX_SIZE_W      = 8;
  localparam int SECT_TYPE_W     = 4;
  localparam int ADDR_LO_W       = 20;
  localparam int ADDR_LO_LSB     = 12;
  localparam int ADDR_HI_W       = 20;
  // section type and protection encodings
  localparam logic [3:0] SECT_INVALID = 4'h0;
  localparam logic [3:0] SECT_VALID   = 4'h1;
  localparam logic [3:0] PROT_CONF_INT = 4'h1;
  localparam logic [3:0] PROT_CONF     = 4'h2;
  // number of protected memory sections built in
  localparam int NUM_SECT = 2;
  // instruction outcome codes
  typedef enum logic [1:0] {
    ENCFE_EXEC_OK = 2'h0,
    ENCFE_EXEC_UD = 2'h1,
    ENCFE_EXEC_GP = 2'h3
  } encfe_outcome_t;
endpackage
